// >>> rtl/dcsoc_pkg.sv
// Purpose: shared constants and types for the sync output control registers
// Assumes: byte-wide register access from two sides, 12-bit byte addresses
// Notes: multi-byte registers are little endian, LSB at the lowest address
package dcsoc_pkg;
  // Register byte addresses
  localparam logic [11:0] OFS_TDIFF_DEPTH = 12'h934;
  localparam logic [11:0] OFS_PDIFF_DEPTH = 12'h935;
  localparam logic [11:0] OFS_OWNER = 12'h980;
  localparam logic [11:0] OFS_ACT = 12'h981;
  localparam logic [11:0] OFS_PLEN_LO = 12'h982;
  localparam logic [11:0] OFS_PLEN_HI = 12'h983;
  localparam logic [11:0] OFS_ACT_STAT = 12'h984;
  localparam logic [11:0] OFS_ACK_A = 12'h98E;
  localparam logic [11:0] OFS_ACK_B = 12'h98F;
  // Reset values
  localparam logic [3:0] TDIFF_DEPTH_RST = 4'h4;
  localparam logic [3:0] PDIFF_DEPTH_RST = 4'hC;
  localparam logic [7:0] OWNER_RST = 8'h00;
  localparam logic [7:0] ACT_RST = 8'h00;
  localparam logic [15:0] PLEN_RST = 16'h0000;
  // Ownership fields
  localparam int OWN_CAP_B = 5;
  localparam int OWN_CAP_A = 4;
  localparam int OWN_SYNC = 0;
  localparam logic [7:0] OWNER_WMASK = 8'h31;
  // Activation fields
  localparam int ACT_DEBUG = 7;
  localparam int ACT_NEAR = 6;
  localparam int ACT_PLAUS = 5;
  localparam int ACT_EXT = 4;
  localparam int ACT_AUTO = 3;
  localparam int ACT_GEN_B = 2;
  localparam int ACT_GEN_A = 1;
  localparam int ACT_ON = 0;
  // Activation status fields
  localparam int STAT_OUTSIDE = 2;
  localparam int STAT_PEND_B = 1;
  localparam int STAT_PEND_A = 0;
  // Timing: pulse length unit against clock period
  localparam logic [4:0] CLK_PERIOD_NS = 5'h08;
  localparam logic [4:0] PULSE_UNIT_NS = 5'h0A;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dcsoc_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } dcsoc_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } dcsoc_state_t;
endpackage

// >>> rtl/dcsoc_shaper.sv
// Purpose: one sync output pulse shaper with timed and acknowledge modes
// Assumes: tick is a one-cycle enable every pulse length unit
// Notes: a new fire wins over a clear in the same cycle
`timescale 1ns/1ns
module dcsoc_shaper (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic fire,
  input wire logic ack_clr,
  input wire logic [15:0] len,
  output logic pulse_q
);
  logic [15:0] cnt_q;
  logic ack_mode_q;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pulse_q <= 1'b0;
      cnt_q <= 16'h0000;
      ack_mode_q <= 1'b0;
    end
    else if (fire)
    begin
      pulse_q <= 1'b1;
      cnt_q <= len;
      ack_mode_q <= (len == 16'h0000);
    end
    else if (pulse_q && ack_mode_q)
    begin
      if (ack_clr)
        pulse_q <= 1'b0;
    end
    else if (pulse_q && tick)
    begin
      // length counted in ten ns units
      if (cnt_q <= 16'h0001)
        pulse_q <= 1'b0;
      cnt_q <= cnt_q - 16'h0001;
    end
  end
endmodule

// >>> rtl/dcsoc_regs.sv
// Purpose: control and status registers of the cyclic sync output unit
// Assumes: both request ports and all time inputs are on core_clk
// Notes: answers come one cycle after each request on both sides
`timescale 1ns/1ns
//
// Contract
// - Four-bit time deviation depth, resets to 4
// - Depth write clears averaged time difference
// - Four-bit period deviation depth, resets to C
// - Depth write resets speed filter state
// - Bit 5 owns second capture, network writes
// - Bit 4 owns first capture, host time forces
// - Bit 0 owns sync output, network writes
// - Activation writes only from sync owner
// - Bit 7 write pings enabled sync outputs
// - Bit 6 picks near-future window size
// - Bit 5 starts at once when outside
// - Bit 4 extends 32-bit start time
// - Bit 3 activates on start time write
// - Bits 2 and 1 enable each output
// - Read-only pulse length in 10 ns
// - Zero length means acknowledge mode
// - Length resets zero unless EEPROM loads
// - Status bit 2 records plausibility result
// - Status bits 1,0 show first pulse pending
// - First output status, host read clears
// - Multi-byte registers little endian
// - Second output status, host read clears
module dcsoc_regs (
  input wire logic core_clk,
  input wire logic arst_n,
  input dcsoc_pkg::dcsoc_req_t net_req,
  input dcsoc_pkg::dcsoc_req_t host_req,
  output dcsoc_pkg::dcsoc_rsp_t net_rsp,
  output dcsoc_pkg::dcsoc_rsp_t host_rsp,
  input wire logic time_by_host,
  input wire logic time_w64,
  input wire logic [63:0] sys_time,
  input wire logic start_wr,
  input wire logic start_wr_host,
  input wire logic start_low_only,
  input wire logic [63:0] start_val,
  input wire logic cyc_evt_a,
  input wire logic cyc_evt_b,
  input wire logic eep_len_vld,
  input wire logic [15:0] eep_len,
  output logic [3:0] tdiff_depth,
  output logic [3:0] pdiff_depth,
  output logic tdiff_clr,
  output logic pdiff_clr,
  output logic cap_a_host,
  output logic cap_b_host,
  output logic sync_host,
  output logic unit_active,
  output logic [63:0] start_eff,
  output logic sync_pulse_a,
  output logic sync_pulse_b
);
  import dcsoc_pkg::*;

  logic [3:0] tdepth_q;
  logic [3:0] pdepth_q;
  logic tclr_q;
  logic pclr_q;
  logic [7:0] own_q;
  logic cap_a_q;
  logic [7:0] act_q;
  logic [15:0] plen_q;
  logic [63:0] start_q;
  logic outside_q;
  logic pend_a_q;
  logic pend_b_q;
  dcsoc_state_t st_q;
  logic [4:0] acc_q;
  logic tick_q;
  dcsoc_rsp_t net_rsp_q;
  dcsoc_rsp_t host_rsp_q;
  logic act_wr;
  logic [7:0] act_wdata;
  logic start_ok;
  logic [31:0] ext_hi;
  logic [63:0] diff;
  logic outside;
  logic reached;
  logic fire_first;
  logic [1:0] fire;
  logic [1:0] clr;
  logic [1:0] pulse;

  function automatic logic hit(input dcsoc_req_t r, input logic [11:0] a, input logic w);
    hit = r.valid && (r.wr == w) && (r.addr == a);
  endfunction

  assign act_wr = own_q[OWN_SYNC] ? hit(host_req, OFS_ACT, 1'b1)
                                  : hit(net_req, OFS_ACT, 1'b1);
  assign act_wdata = own_q[OWN_SYNC] ? host_req.wdata : net_req.wdata;
  // Start time writes follow the same owner
  assign start_ok = start_wr && (start_wr_host == own_q[OWN_SYNC]);
  assign ext_hi = sys_time[63:32] + {31'h0, (start_val[31:0] < sys_time[31:0])};

  // Distance from now to start, wraps on the active width
  assign diff = start_q - sys_time;
  always_comb
  begin
    // window: half width, or 2^31 ns
    if (time_w64 && !act_q[ACT_NEAR])
      outside = diff[63];
    else if (time_w64)
      outside = |diff[63:31];
    else
      outside = diff[31];
    if (time_w64)
      reached = diff[63] || (diff == 64'h0);
    else
      reached = diff[31] || (diff[31:0] == 32'h0);
  end

  always_comb
  begin
    fire_first = 1'b0;
    case (st_q)
      ST_IDLE:
        fire_first = act_q[ACT_ON] && act_q[ACT_PLAUS] && outside;
      ST_WAIT:
        fire_first = act_q[ACT_ON] && reached;
      ST_RUN:
        fire_first = 1'b0;
      default:
        fire_first = 1'b0;
    endcase
  end

  always_comb
  begin
    fire[0] = act_q[ACT_GEN_A] && (fire_first || (st_q == ST_RUN && cyc_evt_a));
    fire[1] = act_q[ACT_GEN_B] && (fire_first || (st_q == ST_RUN && cyc_evt_b));
    if (act_wr && act_wdata[ACT_DEBUG])
    begin
      fire[0] = fire[0] || act_wdata[ACT_GEN_A];
      fire[1] = fire[1] || act_wdata[ACT_GEN_B];
    end
    // host read of first status clears
    clr[0] = hit(host_req, OFS_ACK_A, 1'b0);
    // host read of second status clears
    clr[1] = hit(host_req, OFS_ACK_B, 1'b0);
  end

  // Both sides may write depths; network wins a same-cycle clash
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tdepth_q <= TDIFF_DEPTH_RST;
      tclr_q <= 1'b0;
    end
    else
    begin
      if (hit(net_req, OFS_TDIFF_DEPTH, 1'b1))
        tdepth_q <= net_req.wdata[3:0];
      else if (hit(host_req, OFS_TDIFF_DEPTH, 1'b1))
        tdepth_q <= host_req.wdata[3:0];
      tclr_q <= hit(net_req, OFS_TDIFF_DEPTH, 1'b1) || hit(host_req, OFS_TDIFF_DEPTH, 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pdepth_q <= PDIFF_DEPTH_RST;
      pclr_q <= 1'b0;
    end
    else
    begin
      if (hit(net_req, OFS_PDIFF_DEPTH, 1'b1))
        pdepth_q <= net_req.wdata[3:0];
      else if (hit(host_req, OFS_PDIFF_DEPTH, 1'b1))
        pdepth_q <= host_req.wdata[3:0];
      pclr_q <= hit(net_req, OFS_PDIFF_DEPTH, 1'b1) || hit(host_req, OFS_PDIFF_DEPTH, 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      own_q <= OWNER_RST;
      cap_a_q <= 1'b0;
    end
    else
    begin
      // network side only; host writes dropped
      if (hit(net_req, OFS_OWNER, 1'b1))
        own_q <= net_req.wdata & OWNER_WMASK;
      // host-run system time forces host ownership
      cap_a_q <= own_q[OWN_CAP_A] || time_by_host;
    end
  end

  // non-owner activation writes fall through untouched
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      act_q <= ACT_RST;
    else
    begin
      if (act_wr)
        act_q <= act_wdata;
      if (start_ok && act_q[ACT_AUTO])
        act_q[ACT_ON] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      start_q <= 64'h0;
    else if (start_ok)
    begin
      // upper word from current time, one more when the low word is below current low
      if (act_q[ACT_EXT] && start_low_only)
        start_q <= {ext_hi, start_val[31:0]};
      else
        start_q <= start_val;
    end
  end

  // zero after reset, EEPROM may load it
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      plen_q <= PLEN_RST;
    else if (eep_len_vld)
      plen_q <= eep_len;
  end

  // Activation sequencer; relies on start time already written
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= ST_IDLE;
      outside_q <= 1'b0;
      pend_a_q <= 1'b0;
      pend_b_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (act_q[ACT_ON])
          begin
            outside_q <= outside;
            pend_a_q <= act_q[ACT_GEN_A] && !fire_first;
            pend_b_q <= act_q[ACT_GEN_B] && !fire_first;
            st_q <= fire_first ? ST_RUN : ST_WAIT;
          end
        ST_WAIT:
          if (!act_q[ACT_ON])
          begin
            pend_a_q <= 1'b0;
            pend_b_q <= 1'b0;
            st_q <= ST_IDLE;
          end
          else if (fire_first)
          begin
            pend_a_q <= 1'b0;
            pend_b_q <= 1'b0;
            st_q <= ST_RUN;
          end
        ST_RUN:
          if (!act_q[ACT_ON])
            st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Fractional divider: 10 ns ticks from an 8 ns clock, jitter one cycle
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_q <= 5'h00;
      tick_q <= 1'b0;
    end
    else if (acc_q + CLK_PERIOD_NS >= PULSE_UNIT_NS)
    begin
      acc_q <= acc_q + CLK_PERIOD_NS - PULSE_UNIT_NS;
      tick_q <= 1'b1;
    end
    else
    begin
      acc_q <= acc_q + CLK_PERIOD_NS;
      tick_q <= 1'b0;
    end
  end

  function automatic logic [7:0] rd(input logic [11:0] a);
    case (a)
      OFS_TDIFF_DEPTH: rd = {4'h0, tdepth_q};
      OFS_PDIFF_DEPTH: rd = {4'h0, pdepth_q};
      OFS_OWNER: rd = {own_q[7:5], cap_a_q, own_q[3:0]};
      OFS_ACT: rd = act_q;
      // low byte at the lower address
      OFS_PLEN_LO: rd = plen_q[7:0];
      OFS_PLEN_HI: rd = plen_q[15:8];
      OFS_ACT_STAT: rd = {5'h00, outside_q, pend_b_q, pend_a_q};
      OFS_ACK_A: rd = {7'h00, pulse[0]};
      OFS_ACK_B: rd = {7'h00, pulse[1]};
      default: rd = 8'h00;
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      net_rsp_q <= '0;
      host_rsp_q <= '0;
    end
    else
    begin
      net_rsp_q.valid <= net_req.valid;
      net_rsp_q.rdata <= (net_req.valid && !net_req.wr) ? rd(net_req.addr) : 8'h00;
      host_rsp_q.valid <= host_req.valid;
      host_rsp_q.rdata <= (host_req.valid && !host_req.wr) ? rd(host_req.addr) : 8'h00;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_out
      dcsoc_shaper u_shaper (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(tick_q),
        .fire(fire[g]),
        .ack_clr(clr[g]),
        .len(plen_q),
        .pulse_q(pulse[g])
      );
    end
  endgenerate

  assign net_rsp = net_rsp_q;
  assign host_rsp = host_rsp_q;
  assign tdiff_depth = tdepth_q;
  assign pdiff_depth = pdepth_q;
  assign tdiff_clr = tclr_q;
  assign pdiff_clr = pclr_q;
  assign cap_a_host = cap_a_q;
  assign cap_b_host = own_q[OWN_CAP_B];
  assign sync_host = own_q[OWN_SYNC];
  assign unit_active = act_q[ACT_ON];
  assign start_eff = start_q;
  assign sync_pulse_a = pulse[0];
  assign sync_pulse_b = pulse[1];
endmodule

// >>> bench/dcsoc_regs_monitor.sv
// Purpose: port checks on the sync output control registers
// Assumes: one clock domain
// Notes: bound below to the register block
`timescale 1ns/1ns
module dcsoc_regs_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input dcsoc_pkg::dcsoc_req_t net_req,
  input dcsoc_pkg::dcsoc_req_t host_req,
  input dcsoc_pkg::dcsoc_rsp_t host_rsp,
  input wire logic time_by_host,
  input wire logic start_wr,
  input wire logic tdiff_clr,
  input wire logic pdiff_clr,
  input wire logic cap_a_host,
  input wire logic cap_b_host,
  input wire logic sync_host,
  input wire logic unit_active,
  input wire logic sync_pulse_a,
  input wire logic sync_pulse_b
);
  import dcsoc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  function automatic logic hit(dcsoc_req_t r, logic w, logic [11:0] a);
    return r.valid && r.wr == w && r.addr == a;
  endfunction
  // Excludes every other way bit 0 could move
  sequence s_host_act;
    hit(host_req, 1'b1, OFS_ACT) && !sync_host && !hit(net_req, 1'b1, OFS_ACT) && !start_wr;
  endsequence
  sequence s_ping_a;
    hit(net_req, 1'b1, OFS_ACT) && !sync_host
      && net_req.wdata[ACT_DEBUG] && net_req.wdata[ACT_GEN_A];
  endsequence
  sequence s_ack_b;
    hit(host_req, 1'b0, OFS_ACK_B) ##1 host_rsp.valid;
  endsequence
  chk_tdiff_clear:
  assert property ((hit(net_req, 1'b1, OFS_TDIFF_DEPTH) || hit(host_req, 1'b1, OFS_TDIFF_DEPTH))
    |=> tdiff_clr)
    else $error("time filter clear missing");
  chk_pdiff_clear:
  assert property ((hit(net_req, 1'b1, OFS_PDIFF_DEPTH) || hit(host_req, 1'b1, OFS_PDIFF_DEPTH))
    |-> ##1 pdiff_clr)
    else $error("speed filter clear missing");
  chk_owner_host_ro:
  assert property (hit(host_req, 1'b1, OFS_OWNER) && !hit(net_req, 1'b1, OFS_OWNER)
    |=> $stable({cap_b_host, sync_host}))
    else $error("host changed ownership");
  chk_cap_a_forced:
  assert property (time_by_host |=> cap_a_host)
    else $error("first capture not host owned");
  chk_act_nonowner:
  assert property (s_host_act |=> $stable(unit_active))
    else $error("non-owner changed activation");
  chk_ping_a:
  assert property (s_ping_a |-> ##[1:3] sync_pulse_a)
    else $error("debug ping missing");
  chk_ack_state_a:
  assert property (hit(host_req, 1'b0, OFS_ACK_A) |=> host_rsp.rdata == {7'h00, $past(sync_pulse_a)})
    else $error("first output state wrong");
  chk_ack_state_b:
  assert property (s_ack_b |-> host_rsp.rdata == {7'h00, $past(sync_pulse_b)})
    else $error("second output state wrong");
endmodule

bind dcsoc_regs dcsoc_regs_monitor dcsoc_regs_monitor_inst (.core_clk, .arst_n, .net_req,
  .host_req, .host_rsp, .time_by_host, .start_wr, .tdiff_clr, .pdiff_clr, .cap_a_host,
  .cap_b_host, .sync_host, .unit_active, .sync_pulse_a, .sync_pulse_b);

// >>> bench/dcsoc_time_model.sv
// Purpose: stand-in for system time and the start time register
// Assumes: time advances one clock period per cycle
// Notes: start value is scrambled outside write pulses
`timescale 1ns/1ns
module dcsoc_time_model (
  input wire logic core_clk,
  input wire logic arst_n,
  output logic [63:0] sys_time,
  output logic start_wr,
  output logic start_wr_host,
  output logic start_low_only,
  output logic [63:0] start_val
);
  import dcsoc_pkg::*;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      sys_time <= 64'h0000_0001_8000_0000;
    else
      sys_time <= sys_time + 64'(CLK_PERIOD_NS);
  end
  initial
  begin
    start_wr = 1'b0;
    start_wr_host = 1'b0;
    start_low_only = 1'b0;
    start_val = '1;
  end
  task automatic load(input logic host, input logic low, input logic [63:0] v);
    @(posedge core_clk);
    #1;
    start_wr = 1'b1;
    start_wr_host = host;
    start_low_only = low;
    start_val = v;
    @(posedge core_clk);
    #1;
    start_wr = 1'b0;
    start_val = ~v;
  endtask
endmodule

// >>> bench/tb.sv
// Purpose: self-checking bench for the sync output control registers
// Assumes: network side owns the sync unit unless handed over
// Notes: bus accesses queue their expected byte for the watcher
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    n_checks++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module tb;
  import dcsoc_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  dcsoc_req_t net_req = '0;
  dcsoc_req_t host_req = '0;
  dcsoc_rsp_t net_rsp;
  dcsoc_rsp_t host_rsp;
  logic time_by_host = 1'b0;
  logic time_w64 = 1'b1;
  logic [1:0] cyc_evt = 2'b00;
  logic [3:0] tdiff_depth, pdiff_depth;
  logic eep_len_vld = 1'b0;
  logic [15:0] eep_len = 16'h0000;
  logic sync_pulse_a, sync_pulse_b, start_wr, start_wr_host, start_low_only;
  logic [63:0] sys_time, start_val, start_eff;
  logic [7:0] qn[$], qh[$], ev, d;
  logic [15:0] len;
  logic [19:0] rst_tab[10] = '{{OFS_TDIFF_DEPTH, 8'h04}, {OFS_PDIFF_DEPTH, 8'h0C},
    {OFS_OWNER, 8'h00}, {OFS_ACT, 8'h00}, {OFS_PLEN_LO, 8'h00}, {OFS_PLEN_HI, 8'h00},
    {OFS_ACT_STAT, 8'h00}, {OFS_ACK_A, 8'h00}, {OFS_ACK_B, 8'h00}, {12'h900, 8'h00}};
  int num_errors = 0, n_checks = 0, cyc = 0, seed = 34, hi = 0;
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  dcsoc_time_model dcsoc_time_model_inst (.core_clk, .arst_n, .sys_time, .start_wr,
    .start_wr_host, .start_low_only, .start_val);
  dcsoc_regs dcsoc_regs_inst (.core_clk, .arst_n, .net_req, .host_req, .net_rsp, .host_rsp,
    .time_by_host, .time_w64, .sys_time, .start_wr, .start_wr_host, .start_low_only,
    .start_val, .cyc_evt_a(cyc_evt[0]), .cyc_evt_b(cyc_evt[1]), .eep_len_vld, .eep_len,
    .tdiff_depth, .pdiff_depth, .tdiff_clr(), .pdiff_clr(), .cap_a_host(),
    .cap_b_host(), .sync_host(), .unit_active(), .start_eff, .sync_pulse_a, .sync_pulse_b);
  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic acc(input bit h, input bit w, input logic [11:0] a, input logic [7:0] wd,
                     input logic [7:0] e);
    dcsoc_req_t r;
    r = '{1'b1, w, a, wd};
    @(posedge core_clk);
    #1;
    if (h)
      host_req = r;
    else
      net_req = r;
    if (h)
      qh.push_back(e);
    else
      qn.push_back(e);
    @(posedge core_clk);
    #1;
    // Released bus shows junk, not the last request
    if (h)
      host_req = {1'b0, ~r[20:0]};
    else
      net_req = {1'b0, ~r[20:0]};
  endtask
  task automatic wait_pulse();
    for (int i = 0; i < 200 && sync_pulse_a !== 1'b1; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    `CHK(sync_pulse_a, 1'b1) // rise
  endtask
  always @(negedge core_clk)
  begin
    if (net_rsp.valid === 1'b1)
    begin
      ev = qn.pop_front();
      `CHK(net_rsp.rdata, ev) // readback
    end
    if (host_rsp.valid === 1'b1)
    begin
      ev = qh.pop_front();
      `CHK(host_rsp.rdata, ev) // readback
    end
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    foreach (rst_tab[i])
      acc(0, 0, rst_tab[i][19:8], 8'h00, rst_tab[i][7:0]); // reset
    d = 8'($random(seed));
    acc(0, 1, OFS_TDIFF_DEPTH, d, 8'h00); // clear
    acc(1, 0, OFS_TDIFF_DEPTH, 8'h00, {4'h0, d[3:0]}); // depth
    `CHK(tdiff_depth, d[3:0]) // port
    d = 8'($random(seed));
    acc(1, 1, OFS_PDIFF_DEPTH, d, 8'h00); // clear
    acc(0, 0, OFS_PDIFF_DEPTH, 8'h00, {4'h0, d[3:0]}); // depth
    `CHK(pdiff_depth, d[3:0]) // port
    acc(1, 1, OFS_OWNER, 8'hFF, 8'h00); // refused
    acc(0, 0, OFS_OWNER, 8'h00, 8'h00); // kept
    acc(0, 1, OFS_OWNER, 8'hFF, 8'h00); // owner
    acc(0, 0, OFS_OWNER, 8'h00, 8'h31); // bits
    acc(1, 1, OFS_ACT, 8'h06, 8'h00); // owner
    acc(0, 1, OFS_ACT, 8'h02, 8'h00); // refused
    acc(1, 0, OFS_ACT, 8'h00, 8'h06); // kept
    acc(1, 1, OFS_ACT, 8'h00, 8'h00); // clear
    time_by_host = 1'b1;
    acc(0, 1, OFS_OWNER, 8'h00, 8'h00); // return
    acc(0, 0, OFS_OWNER, 8'h00, 8'h10); // forced
    time_by_host = 1'b0;
    acc(1, 1, OFS_ACT, 8'h01, 8'h00); // refused
    acc(0, 0, OFS_ACT, 8'h00, 8'h00); // kept
    acc(0, 1, OFS_ACT, 8'h82, 8'h00); // ping
    acc(0, 0, OFS_ACK_B, 8'h00, 8'h00); // idle
    acc(0, 0, OFS_ACK_A, 8'h00, 8'h01); // held
    acc(1, 0, OFS_ACK_A, 8'h00, 8'h01); // state
    acc(1, 0, OFS_ACK_A, 8'h00, 8'h00); // cleared
    acc(0, 1, OFS_ACT, 8'h84, 8'h00); // ping
    acc(0, 0, OFS_ACK_A, 8'h00, 8'h00); // idle
    acc(1, 0, OFS_ACK_B, 8'h00, 8'h01); // state
    acc(1, 0, OFS_ACK_B, 8'h00, 8'h00); // cleared
    acc(0, 1, OFS_ACT, 8'h0A, 8'h00); // auto
    dcsoc_time_model_inst.load(1'b0, 1'b0, sys_time + 64'd400);
    acc(0, 0, OFS_ACT, 8'h00, 8'h0B); // set
    acc(0, 0, OFS_ACT_STAT, 8'h00, 8'h01); // pending
    wait_pulse();
    // Rise must come the edge after start is reached, not before
    `CHK((sys_time - start_eff) inside {[64'd1:64'd16]}, 1'b1) // on time
    acc(0, 0, OFS_ACT_STAT, 8'h00, 8'h00); // done
    acc(1, 0, OFS_ACK_A, 8'h00, 8'h01); // clear
    acc(0, 1, OFS_ACT, 8'h00, 8'h00); // stop
    // Pass 2 runs 32-bit time, where half width is 2^31 ns
    for (int n = 0; n < 3; n++)
    begin
      time_w64 = (n != 2);
      dcsoc_time_model_inst.load(1'b0, 1'b0,
        sys_time + (n == 2 ? 64'h0000_0000_8000_1000 : 64'h0000_0001_0000_0000));
      acc(0, 1, OFS_ACT, {1'b0, n == 1, 6'h23}, 8'h00); // check
      acc(0, 0, OFS_ACT, 8'h00, {1'b0, n == 1, 6'h23}); // stored
      acc(0, 0, OFS_ACT_STAT, 8'h00, n > 0 ? 8'h04 : 8'h01); // window
      acc(1, 0, OFS_ACK_A, 8'h00, {7'h00, n > 0}); // at once
      @(posedge core_clk);
      #1;
      cyc_evt = 2'b11;
      @(posedge core_clk);
      #1;
      cyc_evt = 2'b00;
      acc(1, 0, OFS_ACK_A, 8'h00, {7'h00, n > 0}); // cyclic
      acc(1, 0, OFS_ACK_B, 8'h00, 8'h00); // off
      acc(0, 1, OFS_ACT, 8'h00, 8'h00); // stop
    end
    time_w64 = 1'b1;
    acc(0, 1, OFS_ACT, 8'h10, 8'h00); // extend
    dcsoc_time_model_inst.load(1'b0, 1'b1, 64'h0000_0000_0000_0100);
    @(posedge core_clk);
    #1;
    `CHK(start_eff, 64'h0000_0002_0000_0100) // upper
    len = 16'($unsigned($random(seed)) % 7 + 1);
    eep_len = len;
    eep_len_vld = 1'b1;
    @(posedge core_clk);
    #1;
    eep_len_vld = 1'b0;
    eep_len = ~len;
    acc(0, 1, OFS_PLEN_LO, 8'hFF, 8'h00); // read-only
    acc(1, 0, OFS_PLEN_LO, 8'h00, len[7:0]); // low
    acc(1, 0, OFS_PLEN_HI, 8'h00, len[15:8]); // high
    acc(0, 1, OFS_ACT, 8'h82, 8'h00); // ping
    wait_pulse();
    hi = 0;
    while (sync_pulse_a === 1'b1 && hi < 100)
    begin
      @(posedge core_clk);
      #1;
      hi++;
    end
    // Divider jitter allows one clock either way
    `CHK(hi * 8 + 8 >= 10 * len && hi * 8 <= 10 * len + 8, 1'b1) // width
    `CHK(sync_pulse_a, 1'b0) // timed
    `CHK(qn.size() + qh.size(), 0) // drained
    finish_test();
  end
endmodule
